// [wpso_far_end.sv]
// Far-end path terminal model sending received path status octets
module wpso_far_end (
  input wire logic clk,
  input wire logic start,
  input wire logic [7:0] count,
  input wire logic [3:0] gap,
  input wire logic [2:0] code,
  input wire logic [7:0] label,
  output logic busy,
  output logic rx_frame,
  output logic [7:0] rx_status_octet,
  output logic [7:0] rx_payload_label,
  output logic [3:0] rx_parity_errors
);
  timeunit 1ns;
  timeprecision 1ps;
  int seed = 32'h7c1f;
  int left = 0;
  int idle = 0;
  logic go;
  logic [3:0] rei;
  initial begin
    busy = 1'b0;
    rx_frame = 1'b0;
    rx_status_octet = 8'h00;
    rx_payload_label = 8'h00;
    rx_parity_errors = 4'h0;
  end
  // ************************************************************
  // Frame generator, gap 0 gives back-to-back frames
  // ************************************************************
  always @(posedge clk) begin
    go = start;
    #1;
    // Outside a frame the lines carry no stale value
    if (rx_frame) begin
      rx_status_octet = ~rx_status_octet;
      rx_payload_label = ~rx_payload_label;
      rx_parity_errors = ~rx_parity_errors;
    end
    rx_frame = 1'b0;
    if (go && !busy) begin
      left = count;
      idle = 0;
      busy = (count != 8'h00);
    end
    if (busy && idle == 0) begin
      rei = 4'($unsigned($random(seed)) % 9);
      // Spare bit is random: the receiver must not look at it
      rx_status_octet = {rei, code, 1'($random(seed))};
      rx_payload_label = label;
      rx_parity_errors = 4'($unsigned($random(seed)) % 9);
      rx_frame = 1'b1;
      left = left - 1;
      idle = gap;
      busy = (left != 0);
    end else if (idle > 0) begin
      idle = idle - 1;
    end
  end
endmodule // wpso_far_end

// [wpso_pkg.sv]
// Constants and carrier types for the path status overhead block
// Contract
// - Rx and tx modes independent, enhanced after reset
// - Upper nibble carries remote error count 0-8
// - Single mode bit 5; enhanced bits 5-7
// - 000/011 no defect; 100/111 one-bit defect
// - Enhanced codes 001,010,110,101 with priorities
// - Connectivity code on unequipped or trace mismatch
// - Trace mismatch only forced by management
// - Single mode: ten frames set, ten clear
// - Remote defect pending, live copy, masks A/B
// - Enhanced mode: any defect code ten frames
// - Code 010 latches status and pending bit
// - Code 101 latches status and pending bit
// - Code 110 pending, live, remote-defect masks
// - Programmable user channel octet, default zero
// - Programmable multiframe octet, default zero
// - Two programmable growth octets, default zero
// - Programmable tandem octet, default zero
// - Delineation loss latches status and pending bit
// - Back-report delineation loss after over 3 ms
// - After reset back-report until delineation valid
// - Remove back-report after 1 ms absence
// - Remote error count taken from parity FIFO
// - Unequipped after five frames of zero label
package wpso_pkg;
  // ************************************************************
  // Octet layout and codes
  // ************************************************************
  localparam int unsigned G1_REI_LSB = 4;
  localparam int unsigned G1_RDI_BIT = 3;
  localparam logic [2:0] CODE_NONE_A = 3'h0;
  localparam logic [2:0] CODE_NONE_B = 3'h3;
  localparam logic [2:0] CODE_ONE_A = 3'h4;
  localparam logic [2:0] CODE_ONE_B = 3'h7;
  localparam logic [2:0] CODE_E_NONE = 3'h1;
  localparam logic [2:0] CODE_E_PAYLOAD = 3'h2;
  localparam logic [2:0] CODE_E_CONNECT = 3'h6;
  localparam logic [2:0] CODE_E_SERVER = 3'h5;
  localparam logic [7:0] LABEL_UNEQUIPPED = 8'h00;
  localparam logic [7:0] OCTET_DEFAULT = 8'h00;
  localparam logic [3:0] REI_MAX = 4'h8;
  // ************************************************************
  // Persistence and timing
  // ************************************************************
  localparam int unsigned DEFECT_FRAMES = 10;
  localparam int unsigned UNEQ_FRAMES = 5;
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned SET_TIME_US = 3000;
  localparam int unsigned CLR_TIME_US = 1000;
  // More than 3 ms: one cycle beyond the exact 3 ms count
  localparam int unsigned SET_CYCLES = (SET_TIME_US * (CLK_HZ / 1000000)) + 1;
  localparam int unsigned CLR_CYCLES = CLR_TIME_US * (CLK_HZ / 1000000);
  localparam int unsigned FIFO_DEPTH = 16;

  typedef struct packed {
    logic [7:0] user_channel;
    logic [7:0] multiframe;
    logic [7:0] growth_first;
    logic [7:0] growth_second;
    logic [7:0] tandem;
  } wpso_octets_t;

  typedef struct packed {
    logic far_defect;
    logic far_label_or_delin;
    logic far_alarm_or_ptr;
    logic far_unequipped;
    logic delin_loss;
  } wpso_events_t;
endpackage

// [wpso_top.sv]
// Path status octet handling, error-count FIFO and delineation tracking
// ************************************************************
// Small FIFO carrying remote error counts
// ************************************************************
module wpso_fifo #(
  parameter int unsigned WIDTH = 4,
  parameter int unsigned DEPTH = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic ready_q;
  wire do_wr = in_valid && in_ready;
  wire do_rd = out_valid && out_ready;
  wire [AW:0] cnt_d = cnt_q + (AW+1)'(do_wr) - (AW+1)'(do_rd);
  // Registered from the next count: same timing as a compare, but a flop output
  assign in_ready = ready_q;
  assign out_valid = cnt_q != '0;
  assign out_data = mem[rd_q];
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wr_q] <= in_data;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      ready_q <= 1'b1;
    end else begin
      if (do_wr) wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      if (do_rd) rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      cnt_q <= cnt_d;
      ready_q <= cnt_d < (AW+1)'(DEPTH);
    end
  end
endmodule // wpso_fifo

// ************************************************************
// Top level
// ************************************************************
module wpso_top #(
  parameter int unsigned SET_CYCLES = wpso_pkg::SET_CYCLES,
  parameter int unsigned CLR_CYCLES = wpso_pkg::CLR_CYCLES
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic RX_ENHANCED_DEFECT_SELECT,
  input wire logic TX_ENHANCED_DEFECT_SELECT,
  input wire logic RX_FRAME,
  input wire logic [7:0] RX_STATUS_OCTET,
  input wire logic [7:0] RX_PAYLOAD_LABEL,
  input wire logic [3:0] RX_PARITY_ERRORS,
  output logic RX_PARITY_READY,
  input wire logic TX_FRAME,
  output logic [7:0] TX_STATUS_OCTET,
  input wire wpso_pkg::wpso_octets_t TX_OCTETS_IN,
  output wpso_pkg::wpso_octets_t TX_OCTETS,
  input wire logic FORCE_TRACE_MISMATCH,
  input wire logic NEAR_SERVER_DEFECT,
  input wire logic NEAR_PAYLOAD_DEFECT,
  input wire logic PCS_DELIN_LOSS,
  input wire wpso_pkg::wpso_events_t PENDING_READ,
  input wire wpso_pkg::wpso_events_t IRQ_A_ENABLE,
  input wire wpso_pkg::wpso_events_t IRQ_B_ENABLE,
  output wpso_pkg::wpso_events_t PENDING,
  output wpso_pkg::wpso_events_t LATCHED,
  output logic FAR_DEFECT_LIVE,
  output logic FAR_UNEQUIPPED_LIVE,
  output logic DELIN_BACK_REPORT,
  output logic IRQ_OUT_A,
  output logic IRQ_OUT_B
);
  localparam int unsigned TW = $clog2(SET_CYCLES + 1);

  // ************************************************************
  // Pin synchroniser for the PCS delineation alarm
  // ************************************************************
  logic [2:0] delin_sync_q;
  logic delin_loss_q;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      delin_sync_q <= 3'h7;
      delin_loss_q <= 1'b1;
    end else begin
      delin_sync_q <= {delin_sync_q[1:0], PCS_DELIN_LOSS};
      if (delin_sync_q[1] == delin_sync_q[2]) delin_loss_q <= delin_sync_q[2];
    end
  end

  // ************************************************************
  // Receive decode
  // ************************************************************
  wire [2:0] rx_code = RX_STATUS_OCTET[wpso_pkg::G1_RDI_BIT -: 3];
  // Bit 8 of the octet never enters the decode
  wire rx_one_bit = (rx_code == wpso_pkg::CODE_ONE_A) || (rx_code == wpso_pkg::CODE_ONE_B);
  wire rx_payload = rx_code == wpso_pkg::CODE_E_PAYLOAD;
  wire rx_server = rx_code == wpso_pkg::CODE_E_SERVER;
  wire rx_connect = rx_code == wpso_pkg::CODE_E_CONNECT;
  wire rx_ind = RX_ENHANCED_DEFECT_SELECT ? (rx_payload | rx_server | rx_connect)
                                          : rx_one_bit;

  logic [3:0] on_cnt_q;
  logic [3:0] off_cnt_q;
  logic far_def_q;
  logic [2:0] uneq_cnt_q;
  logic uneq_q;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      on_cnt_q <= '0;
      off_cnt_q <= '0;
      far_def_q <= 1'b0;
    end else if (RX_FRAME) begin
      on_cnt_q <= rx_ind ? ((on_cnt_q == 4'(wpso_pkg::DEFECT_FRAMES)) ? on_cnt_q
                                                                       : on_cnt_q + 1'b1) : '0;
      off_cnt_q <= !rx_ind ? ((off_cnt_q == 4'(wpso_pkg::DEFECT_FRAMES)) ? off_cnt_q
                                                                         : off_cnt_q + 1'b1) : '0;
      if (rx_ind && on_cnt_q == 4'(wpso_pkg::DEFECT_FRAMES - 1)) far_def_q <= 1'b1;
      if (!rx_ind && off_cnt_q == 4'(wpso_pkg::DEFECT_FRAMES - 1)) far_def_q <= 1'b0;
    end
  end

  // Unequipped label acceptance
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      uneq_cnt_q <= '0;
      uneq_q <= 1'b0;
    end else if (RX_FRAME) begin
      if (RX_PAYLOAD_LABEL == wpso_pkg::LABEL_UNEQUIPPED) begin
        if (uneq_cnt_q != 3'(wpso_pkg::UNEQ_FRAMES)) uneq_cnt_q <= uneq_cnt_q + 1'b1;
        if (uneq_cnt_q >= 3'(wpso_pkg::UNEQ_FRAMES - 1)) uneq_q <= 1'b1;
      end else begin
        uneq_cnt_q <= '0;
        uneq_q <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Delineation persistence timers
  // ************************************************************
  logic [TW-1:0] dl_cnt_q;
  logic back_rep_q;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      dl_cnt_q <= '0;
      back_rep_q <= 1'b1;
    end else if (delin_loss_q == back_rep_q) begin
      dl_cnt_q <= '0;
    end else if (!back_rep_q && dl_cnt_q == TW'(SET_CYCLES - 1)) begin
      back_rep_q <= 1'b1;
      dl_cnt_q <= '0;
    end else if (back_rep_q && dl_cnt_q == TW'(CLR_CYCLES - 1)) begin
      back_rep_q <= 1'b0;
      dl_cnt_q <= '0;
    end else begin
      dl_cnt_q <= dl_cnt_q + 1'b1;
    end
  end

  // ************************************************************
  // Events, pending bits and interrupts
  // ************************************************************
  logic far_def_d1_q;
  logic delin_d1_q;
  wpso_pkg::wpso_events_t ev;
  assign ev.far_defect = far_def_q && !far_def_d1_q;
  assign ev.far_label_or_delin = RX_FRAME && RX_ENHANCED_DEFECT_SELECT && rx_payload;
  assign ev.far_alarm_or_ptr = RX_FRAME && RX_ENHANCED_DEFECT_SELECT && rx_server;
  assign ev.far_unequipped = RX_FRAME && RX_ENHANCED_DEFECT_SELECT && rx_connect;
  assign ev.delin_loss = delin_loss_q && !delin_d1_q;
  wire [4:0] pend_d = ev | (PENDING & ~PENDING_READ); // Set beats read-clear
  wire [4:0] latch_d = ev | (LATCHED & ~PENDING_READ) | {4'h0, delin_loss_q};
  // Unequipped shares the remote-defect masks
  wire [4:0] mask_a = {IRQ_A_ENABLE[4:2], IRQ_A_ENABLE[4], IRQ_A_ENABLE[0]};
  wire [4:0] mask_b = {IRQ_B_ENABLE[4:2], IRQ_B_ENABLE[4], IRQ_B_ENABLE[0]};

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      far_def_d1_q <= 1'b0;
      delin_d1_q <= 1'b1;
      PENDING <= '0;
      LATCHED <= '0;
      FAR_DEFECT_LIVE <= 1'b0;
      FAR_UNEQUIPPED_LIVE <= 1'b0;
      IRQ_OUT_A <= 1'b0;
      IRQ_OUT_B <= 1'b0;
    end else begin
      far_def_d1_q <= far_def_q;
      delin_d1_q <= delin_loss_q;
      PENDING <= pend_d;
      LATCHED <= latch_d;
      FAR_DEFECT_LIVE <= far_def_q;
      if (RX_FRAME && RX_ENHANCED_DEFECT_SELECT) FAR_UNEQUIPPED_LIVE <= rx_connect;
      IRQ_OUT_A <= |(pend_d & mask_a);
      IRQ_OUT_B <= |(pend_d & mask_b);
    end
  end

  // ************************************************************
  // Transmit status octet and programmable octets
  // ************************************************************
  logic [3:0] rei_fifo;
  logic rei_valid;
  wpso_fifo #(.WIDTH(4), .DEPTH(wpso_pkg::FIFO_DEPTH)) u_fifo (
    .clk(CLK),
    .reset_n(RESET_N),
    .in_valid(RX_FRAME),
    .in_ready(RX_PARITY_READY),
    .in_data(RX_PARITY_ERRORS > wpso_pkg::REI_MAX ? wpso_pkg::REI_MAX : RX_PARITY_ERRORS),
    .out_valid(rei_valid),
    .out_ready(TX_FRAME),
    .out_data(rei_fifo)
  );
  // Empty FIFO sends zero: rate slip is not an error
  wire [3:0] rei = rei_valid ? rei_fifo : 4'h0;
  wire connect_near = uneq_q || FORCE_TRACE_MISMATCH;
  wire [2:0] e_code = NEAR_SERVER_DEFECT ? wpso_pkg::CODE_E_SERVER
                    : connect_near ? wpso_pkg::CODE_E_CONNECT
                    : NEAR_PAYLOAD_DEFECT ? wpso_pkg::CODE_E_PAYLOAD
                    : wpso_pkg::CODE_E_NONE;
  wire one_near = NEAR_SERVER_DEFECT;
  wire [2:0] tx_code = TX_ENHANCED_DEFECT_SELECT ? e_code : {one_near, 2'b00};

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      TX_STATUS_OCTET <= 8'h00;
      TX_OCTETS <= {5{wpso_pkg::OCTET_DEFAULT}};
    end else if (TX_FRAME) begin
      TX_STATUS_OCTET <= {rei, tx_code, 1'b0};
      TX_OCTETS <= TX_OCTETS_IN;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  a_back_report_reset: assert property (@(posedge CLK) disable iff (!RESET_N)
    $rose(RESET_N) |-> DELIN_BACK_REPORT) else $error("back report low after reset");
  a_rei_range: assert property (@(posedge CLK) disable iff (!RESET_N)
    TX_STATUS_OCTET[7:4] <= wpso_pkg::REI_MAX) else $error("rei above eight");
  a_single_zero: assert property (@(posedge CLK) disable iff (!RESET_N)
    TX_FRAME && !TX_ENHANCED_DEFECT_SELECT |=> TX_STATUS_OCTET[2:1] == 2'b00)
    else $error("bits six seven set");
  a_server_prio: assert property (@(posedge CLK) disable iff (!RESET_N)
    TX_FRAME && TX_ENHANCED_DEFECT_SELECT && NEAR_SERVER_DEFECT
    |=> TX_STATUS_OCTET[3:1] == wpso_pkg::CODE_E_SERVER) else $error("server not first");
  a_forced_tim: assert property (@(posedge CLK) disable iff (!RESET_N)
    TX_FRAME && TX_ENHANCED_DEFECT_SELECT && FORCE_TRACE_MISMATCH && !NEAR_SERVER_DEFECT
    |=> TX_STATUS_OCTET[3:1] == wpso_pkg::CODE_E_CONNECT) else $error("forced tim lost");
  a_pending_hold: assert property (@(posedge CLK) disable iff (!RESET_N)
    PENDING.delin_loss && !PENDING_READ.delin_loss |=> PENDING.delin_loss)
    else $error("pending dropped unread");
  a_far_live: assert property (@(posedge CLK) disable iff (!RESET_N)
    $rose(far_def_q) |=> FAR_DEFECT_LIVE ##1 PENDING.far_defect)
    else $error("far defect not reported");
  a_server_latch: assert property (@(posedge CLK) disable iff (!RESET_N)
    ev.far_alarm_or_ptr |=> LATCHED.far_alarm_or_ptr && PENDING.far_alarm_or_ptr)
    else $error("server code not latched");
  a_payload_latch: assert property (@(posedge CLK) disable iff (!RESET_N)
    ev.far_label_or_delin |=> LATCHED.far_label_or_delin)
    else $error("payload code not latched");
  a_user_octet: assert property (@(posedge CLK) disable iff (!RESET_N)
    TX_FRAME |=> TX_OCTETS == $past(TX_OCTETS_IN)) else $error("octet not inserted");
  c_far_defect: cover property (@(posedge CLK) disable iff (!RESET_N) $rose(FAR_DEFECT_LIVE));
  c_back_clear: cover property (@(posedge CLK) disable iff (!RESET_N) $fell(DELIN_BACK_REPORT));
  c_unequipped: cover property (@(posedge CLK) disable iff (!RESET_N) $rose(uneq_q));
  c_irq_a: cover property (@(posedge CLK) disable iff (!RESET_N) $rose(IRQ_OUT_A));

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      DELIN_BACK_REPORT <= 1'b1;
    end else begin
      DELIN_BACK_REPORT <= back_rep_q;
    end
  end
endmodule // wpso_top

// [wpso_top_test.sv]
// Self-checking bench for the path status overhead block
module wpso_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset_n, rx_sel, tx_sel, tx_frame, force_tim, near_srv, near_pay, pcs_loss;
  logic rx_frame, ready, busy, start, live, uneq_live, back, irq_a, irq_b, tx_seen;
  logic [7:0] rx_oct, rx_label, label, tx_oct, count;
  logic [3:0] rx_par, gap;
  logic [2:0] code;
  wpso_pkg::wpso_octets_t oct_in, oct_out;
  wpso_pkg::wpso_events_t rd, en_a, en_b, pend, latch;
  logic [47:0] exp_q[$];
  logic [3:0] fifo_m[$];
  int seed = 32'h7c1f;
  int n_mismatch = 0;
  int n_compared = 0;
  int i;
  // Short persistence counts keep the run brief
  wpso_top #(.SET_CYCLES(20), .CLR_CYCLES(10)) u_dut (
    .CLK(clk), .RESET_N(reset_n), .RX_ENHANCED_DEFECT_SELECT(rx_sel),
    .TX_ENHANCED_DEFECT_SELECT(tx_sel), .RX_FRAME(rx_frame), .RX_STATUS_OCTET(rx_oct),
    .RX_PAYLOAD_LABEL(rx_label), .RX_PARITY_ERRORS(rx_par), .RX_PARITY_READY(ready),
    .TX_FRAME(tx_frame), .TX_STATUS_OCTET(tx_oct), .TX_OCTETS_IN(oct_in), .TX_OCTETS(oct_out),
    .FORCE_TRACE_MISMATCH(force_tim), .NEAR_SERVER_DEFECT(near_srv),
    .NEAR_PAYLOAD_DEFECT(near_pay), .PCS_DELIN_LOSS(pcs_loss), .PENDING_READ(rd),
    .IRQ_A_ENABLE(en_a), .IRQ_B_ENABLE(en_b), .PENDING(pend), .LATCHED(latch),
    .FAR_DEFECT_LIVE(live), .FAR_UNEQUIPPED_LIVE(uneq_live), .DELIN_BACK_REPORT(back),
    .IRQ_OUT_A(irq_a), .IRQ_OUT_B(irq_b));
  wpso_far_end u_far (
    .clk(clk), .start(start), .count(count), .gap(gap), .code(code), .label(label),
    .busy(busy), .rx_frame(rx_frame), .rx_status_octet(rx_oct),
    .rx_payload_label(rx_label), .rx_parity_errors(rx_par));
  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    n_compared++;
    if (seen !== want) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic send(input int n, input logic [2:0] c);
    int k;
    code = c;
    count = 8'(n);
    start = 1'b1;
    cyc(1);
    start = 1'b0;
    cyc(1);
    for (k = 0; k < 300 && busy; k++) cyc(1);
    if (busy) begin
      n_mismatch++;
      finish_test();
    end
    cyc(3);
  endtask
  // Leaves the strobe high so frames can run back to back
  task automatic tx(input logic uq);
    logic [3:0] r;
    logic [2:0] c;
    oct_in = {32'($random(seed)), 8'($random(seed))};
    r = (fifo_m.size() > 0) ? fifo_m.pop_front() : 4'h0;
    if (!tx_sel) c = {near_srv, 2'b00};
    else if (near_srv) c = wpso_pkg::CODE_E_SERVER;
    else if (force_tim || uq) c = wpso_pkg::CODE_E_CONNECT;
    else if (near_pay) c = wpso_pkg::CODE_E_PAYLOAD;
    else c = wpso_pkg::CODE_E_NONE;
    exp_q.push_back({r, c, 1'b0, oct_in});
    tx_frame = 1'b1;
    cyc(1);
  endtask
  // ************************************************************
  // Clock, monitor and sequence
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    if (!reset_n) begin
      fifo_m.delete();
    end else if (rx_frame) begin
      check(ready, fifo_m.size() < wpso_pkg::FIFO_DEPTH);
      if (fifo_m.size() < wpso_pkg::FIFO_DEPTH) fifo_m.push_back(rx_par);
    end
    if (tx_seen) check({tx_oct, oct_out}, exp_q.pop_front());
    tx_seen = tx_frame && reset_n;
  end
  initial begin
    reset_n = 1'b0;
    {rx_sel, tx_sel, tx_frame, force_tim, near_srv, near_pay, pcs_loss} = 7'h60;
    {start, tx_seen, rd, en_a, en_b} = 17'h0;
    oct_in = 40'h0;
    count = 8'h00;
    gap = 4'h0;
    code = 3'h0;
    label = 8'h5c;
    cyc(1);
    check({back, pend, latch, oct_out}, {1'b1, 50'h0});
    cyc(5);
    reset_n = 1'b1;
    cyc(1);
    check(back, 1'b1);
    cyc(25);
    check(back, 1'b0);
    en_b = 5'h01;
    pcs_loss = 1'b1;
    cyc(15);
    pcs_loss = 1'b0;
    cyc(8);
    check({back, irq_b, latch.delin_loss, pend.delin_loss}, 4'h7);
    en_b = 5'h00;
    cyc(2);
    check(irq_b, 1'b0);
    rd = 5'h01;
    cyc(1);
    rd = 5'h00;
    cyc(2);
    check({latch.delin_loss, pend.delin_loss}, 2'h0);
    pcs_loss = 1'b1;
    cyc(30);
    check(back, 1'b1);
    pcs_loss = 1'b0;
    cyc(6);
    check(back, 1'b1);
    cyc(12);
    check(back, 1'b0);
    rx_sel = 1'b0;
    en_a = 5'h10;
    gap = 4'h2;
    send(9, 3'h4);
    check(live, 1'b0);
    send(1, 3'h7);
    check({live, pend.far_defect, irq_a}, 3'h7);
    send(1, 3'h2);
    check(latch.far_label_or_delin, 1'b0);
    gap = 4'h0;
    send(8, 3'h3);
    check(live, 1'b1);
    send(1, 3'h0);
    check(live, 1'b0);
    rd = 5'h10;
    cyc(1);
    rd = 5'h00;
    cyc(2);
    check({pend.far_defect, irq_a}, 2'h0);
    rx_sel = 1'b1;
    en_a = 5'h00;
    en_b = 5'h10;
    send(1, 3'h6);
    check({pend.far_unequipped, irq_b, irq_a}, 3'h6);
    send(8, 3'h6);
    check(live, 1'b0);
    send(1, 3'h6);
    check({live, uneq_live}, 2'h3);
    send(1, 3'h2);
    check({latch.far_label_or_delin, pend.far_label_or_delin}, 2'h3);
    send(1, 3'h5);
    check({latch.far_alarm_or_ptr, pend.far_alarm_or_ptr}, 2'h3);
    send(9, 3'h1);
    check(live, 1'b1);
    send(1, 3'h1);
    check(live, 1'b0);
    // Full FIFO drained by every mode and defect mix, then two more
    for (i = 0; i < 18; i++) begin
      {tx_sel, near_srv, force_tim, near_pay} = 4'(i);
      tx(1'b0);
    end
    tx_frame = 1'b0;
    {tx_sel, near_srv, force_tim, near_pay} = 4'h8;
    label = 8'h00;
    send(4, 3'h1);
    tx(1'b0);
    tx_frame = 1'b0;
    send(1, 3'h1);
    tx(1'b1);
    tx_frame = 1'b0;
    // Let the monitor see the last octet before reset clears it
    cyc(1);
    reset_n = 1'b0;
    cyc(2);
    check({back, pend, oct_out}, {1'b1, 45'h0});
    reset_n = 1'b1;
    cyc(2);
    tx(1'b0);
    tx_frame = 1'b0;
    cyc(3);
    finish_test();
  end
endmodule // wpso_top_test
